// file: rtl/clk_div_consts.vh
// Constants for the filter clock source selection and divider.
`ifndef CLK_DIV_CONSTS_VH
`define CLK_DIV_CONSTS_VH
`define LVL_NEG       2'h0
`define LVL_GND       2'h1
`define LVL_POS       2'h2
`define LVL_BAD       2'h3
`define DIV_POS       10'h2cc
`define DIV_GND       10'h254
`define DIV_NEG       10'h002
`define RATIO_POS_X100 14'h0d05
`define RATIO_GND_X100 14'h1388
`define RATIO_NEG_X100 14'h2710
`define MODE_OSC      2'h0
`define MODE_CMOS     2'h1
`define MODE_TTL      2'h2
`define MODE_OFF      2'h3
`endif

// file: rtl/level_decode.v
// Three-level setting decoder with invalid-code detection.
`timescale 1ns/10ps
`include "clk_div_consts.vh"
module level_decode (
  input  wire       sys_clk_in,
  input  wire       reset_n_in,
  input  wire [1:0] level_in,
  output reg  [1:0] level_out,
  output reg        invalid_out
);
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  // Settings are static straps from pins, so they pass three flip-flops: sync_a, sync_b and level_out.
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a      <= `LVL_GND;
      sync_b      <= `LVL_GND;
      level_out   <= `LVL_GND;
      invalid_out <= 1'b0;
    end else begin
      sync_a <= level_in;
      sync_b <= sync_a;
      // The fourth code is flagged and the last good level is kept.
      invalid_out <= (sync_b == `LVL_BAD);
      if (sync_b != `LVL_BAD) begin
        level_out <= sync_b;
      end
    end
  end
endmodule // level_decode

// file: rtl/filter_clock_source_divider.v
// Filter clock source selection and programmable divider.
// Function
// - Divider divides by 716, 596 or 2 for positive, ground, negative.
// - Positive source select enables oscillator and divider, clock pin output.
// - Ground source select disables divider; clock pin is CMOS input.
// - Negative source select disables divider; clock pin is TTL input.
// - Oscillator or external clock on osc_in is divided before use.
// - In divider mode the clock pin carries the divider output.
// - Ratio select gives 33.33, 50 or 100 clock-to-center ratio.
`timescale 1ns/10ps
`include "clk_div_consts.vh"
module filter_clock_source_divider (
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  input  wire [1:0]  divide_select_in,
  input  wire [1:0]  clock_source_select_in,
  input  wire [1:0]  ratio_select_in,
  input  wire        osc_in,
  input  wire        filter_clk_in,
  output reg         osc_out,
  output reg         filter_clk_out,
  output reg         filter_clk_oe_out,
  output reg         filter_clk_tick_out,
  output reg  [1:0]  mode_out,
  output reg  [13:0] ratio_x100_out,
  output reg         setting_invalid_out
);
  wire [1:0] div_lvl;
  wire [1:0] src_lvl;
  wire [1:0] rat_lvl;
  wire       div_bad;
  wire       src_bad;
  wire       rat_bad;
  reg        osc_a;
  reg        osc_b;
  reg        osc_c;
  reg        pin_a;
  reg        pin_b;
  reg        pin_c;
  reg  [9:0] count;
  reg        div_q;
  reg        next_tick;

  function [9:0] half_count;
    input [1:0] lvl;
    begin
      case (lvl)
        `LVL_POS: half_count = `DIV_POS >> 1;
        `LVL_GND: half_count = `DIV_GND >> 1;
        default:  half_count = `DIV_NEG >> 1;
      endcase
    end
  endfunction

  level_decode u_div (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .level_in    (divide_select_in),
    .level_out   (div_lvl),
    .invalid_out (div_bad)
  );
  level_decode u_src (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .level_in    (clock_source_select_in),
    .level_out   (src_lvl),
    .invalid_out (src_bad)
  );
  level_decode u_rat (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .level_in    (ratio_select_in),
    .level_out   (rat_lvl),
    .invalid_out (rat_bad)
  );

  wire osc_en = (src_lvl == `LVL_POS);
  wire osc_rise = osc_b & ~osc_c;
  wire pin_rise = pin_b & ~pin_c;

  always @* begin
    // Oscillator mode ticks with the pin's rising edge, so the pulse and
    // the new high level of the clock pin leave their flip-flops together.
    if (osc_en) begin
      next_tick = div_q && !filter_clk_out;
    end else begin
      next_tick = pin_rise;
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_a <= 1'b0;
      osc_b <= 1'b0;
      osc_c <= 1'b0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      pin_c <= 1'b0;
      count <= 10'h000;
      div_q <= 1'b0;
      osc_out <= 1'b0;
      filter_clk_out <= 1'b0;
      filter_clk_oe_out <= 1'b0;
      filter_clk_tick_out <= 1'b0;
      mode_out <= `MODE_CMOS;
      ratio_x100_out <= `RATIO_GND_X100;
      setting_invalid_out <= 1'b0;
    end else begin
      osc_a <= osc_in;
      osc_b <= osc_a;
      osc_c <= osc_b;
      pin_a <= filter_clk_in;
      pin_b <= pin_a;
      pin_c <= pin_b;
      // Inverting buffer models the crystal amplifier; held low when off.
      osc_out <= osc_en & ~osc_b;
      if (!osc_en) begin
        count <= 10'h000;
        div_q <= 1'b0;
      end else if (osc_rise) begin
        // Each half period lasts half the factor of input rises.
        if (count + 10'h001 >= half_count(div_lvl)) begin
          count <= 10'h000;
          div_q <= ~div_q;
        end else begin
          count <= count + 10'h001;
        end
      end
      filter_clk_out <= osc_en & div_q;
      filter_clk_oe_out <= osc_en;
      filter_clk_tick_out <= next_tick;
      case (src_lvl)
        `LVL_POS: mode_out <= `MODE_OSC;
        `LVL_GND: mode_out <= `MODE_CMOS;
        `LVL_NEG: mode_out <= `MODE_TTL;
        default:  mode_out <= `MODE_OFF;
      endcase
      case (rat_lvl)
        `LVL_POS: ratio_x100_out <= `RATIO_POS_X100;
        `LVL_GND: ratio_x100_out <= `RATIO_GND_X100;
        default:  ratio_x100_out <= `RATIO_NEG_X100;
      endcase
      setting_invalid_out <= div_bad | src_bad | rat_bad;
    end
  end
endmodule // filter_clock_source_divider

// file: tb/clk_div_props.sv
// Assertions on the filter clock source and divider ports.
`timescale 1ns/10ps
module clk_div_props (
  input wire logic        sys_clk_in, reset_n_in, filter_clk_out, osc_out,
  input wire logic        filter_clk_oe_out, filter_clk_tick_out,
  input wire logic        setting_invalid_out,
  input wire logic [1:0]  clock_source_select_in, ratio_select_in, mode_out,
  input wire logic [13:0] ratio_x100_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_osc; (clock_source_select_in == 2'h2) [*6] |->
    mode_out == 2'h0 && filter_clk_oe_out; endproperty
  a_osc: assert property (p_osc) else $error("no drive");
  property p_cmos; mode_out == 2'h1 |-> !filter_clk_oe_out; endproperty
  a_cmos: assert property (p_cmos) else $error("cmos drive");
  property p_ttl; mode_out == 2'h2 |-> !filter_clk_oe_out; endproperty
  a_ttl: assert property (p_ttl) else $error("ttl drive");
  property p_still; (mode_out != 2'h0) [*3] |=> $stable(filter_clk_out);
  endproperty
  a_still: assert property (p_still) else $error("divider runs");
  property p_xoff; (mode_out != 2'h0) [*3] |-> !osc_out; endproperty
  a_xoff: assert property (p_xoff) else $error("osc runs");
  property p_tick; $rose(filter_clk_out) |-> ##[0:1] filter_clk_tick_out;
  endproperty
  a_tick: assert property (p_tick) else $error("no tick");
  property p_ratio; (ratio_select_in == 2'h2) [*6] |->
    ratio_x100_out == 14'h0d05; endproperty
  a_ratio: assert property (p_ratio) else $error("bad ratio");
  property p_bad; (ratio_select_in == 2'h3) [*5] |-> setting_invalid_out;
  endproperty
  a_bad: assert property (p_bad) else $error("no invalid flag");
  c_tick: cover property (filter_clk_tick_out);
  c_ttl: cover property (mode_out == 2'h2);
  c_bad: cover property (setting_invalid_out);
endmodule // clk_div_props
bind filter_clock_source_divider clk_div_props i_props (.*);

// file: tb/ext_clock_source.sv
// Crystal and external pin clock model beside the divider.
`timescale 1ns/10ps
module ext_clock_source (
  input  wire logic sys_clk_in,
  input  wire logic osc_en_in,
  output logic      osc_out,
  output logic      pin_clk_out
);
  logic [1:0] phase = 2'h0;
  initial osc_out = 1'b0;
  initial pin_clk_out = 1'b0;
  // Both clocks keep an even duty so half periods are exact.
  always @(posedge sys_clk_in) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) begin
      osc_out <= osc_en_in & !osc_out;
      pin_clk_out <= !pin_clk_out;
    end
  end
endmodule // ext_clock_source

// file: tb/filter_clock_source_divider_bench.sv
// Self-checking bench for the filter clock source and divider.
`timescale 1ns/10ps
module filter_clock_source_divider_bench;
  logic sys_clk_in = 0, reset_n_in = 0, osc, pclk, fclk, oe, tick, xo, bad;
  logic [1:0]  div = 2'h1, src = 2'h2, rat = 2'h1, mode;
  logic [13:0] ratio;
  logic [29:0] rows [3] = '{{2'h2, 2'h2, 12'h2cc, 14'h0d05},
    {2'h1, 2'h1, 12'h254, 14'h1388}, {2'h0, 2'h0, 12'h002, 14'h2710}};
  int mismatches = 0, n_compared = 0, cyc = 0, n;
  initial forever #10 sys_clk_in = !sys_clk_in;
  ext_clock_source i_src (.sys_clk_in, .osc_en_in(oe), .osc_out(osc),
    .pin_clk_out(pclk));
  filter_clock_source_divider i_dut (.sys_clk_in, .reset_n_in,
    .divide_select_in(div), .clock_source_select_in(src),
    .ratio_select_in(rat), .osc_in(osc), .filter_clk_in(oe ? fclk : pclk),
    .osc_out(xo), .filter_clk_out(fclk), .filter_clk_oe_out(oe),
    .filter_clk_tick_out(tick), .mode_out(mode), .ratio_x100_out(ratio),
    .setting_invalid_out(bad));
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic period(output int c);
    c = 0;
    while (tick !== 1'b1 && c < 20000) begin @(negedge sys_clk_in); c++; end
    c = 0;
    do begin @(negedge sys_clk_in); c++; end
    while (tick !== 1'b1 && c < 20000);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin mismatches++; results; end
  end
  task automatic settle(input logic [1:0] s, r);
    @(posedge sys_clk_in);
    src <= s;
    rat <= r;
    repeat (8) @(negedge sys_clk_in);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk_in);
    check(mode, 2'h1);
    check(ratio, 14'h1388);
    @(posedge sys_clk_in);
    reset_n_in <= 1;
    foreach (rows[i]) begin
      @(posedge sys_clk_in);
      div <= rows[i][29:28];
      rat <= rows[i][27:26];
      period(n);
      period(n);
      check(n, rows[i][25:14] * 8);
      check(ratio, rows[i][13:0]);
      check({oe, mode}, 3'h4);
    end
    settle(2'h2, 2'h3);
    check({bad, ratio}, 15'h6710);
    settle(2'h1, 2'h1);
    check({oe, mode}, 3'h1);
    period(n);
    period(n);
    check(n, 32'h8);
    settle(2'h0, 2'h1);
    check({oe, xo, mode}, 4'h2);
    period(n);
    period(n);
    check(n, 32'h8);
    results;
  end
endmodule // filter_clock_source_divider_bench
